// [bench/drc_top_tb.sv]
`timescale 1ns/1ps
module drc_top_tb import drc_pkg::*;;
  typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] e;} drc_tb_row_t;
  logic aclk, aresetn, awv, wv, bre, arv, rre, pin_in, dig_out, dig_oe;
  logic awr, wr, bv, arr, rv, pin_out, pin_oe, pin_in_en, pin_read;
  logic [3:0] aw, ws, ar;
  logic [31:0] wd, rdata, d;
  logic [1:0] bresp, rresp, r, sc;
  logic [7:0] c, lv;
  drc_analog_t an;
  int n_mismatch, checked;
  drc_tb_row_t rows [6] = '{'{4'h0, 8'hff, 8'hac}, '{4'h0, 8'h53, 8'h00},
    '{4'h0, 8'h84, 8'h84}, '{4'h4, 8'ha5, 8'ha5}, '{4'h4, 8'hff, 8'hff},
    '{4'h0, 8'h8c, 8'h8c}};

  drc_top drc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .pin_in(pin_in), .pin_dig_out(dig_out), .pin_dig_oe(dig_oe), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in_en(pin_in_en), .pin_read(pin_read), .analog(an));

  always #12.5 aclk = ~aclk;

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task chk_data(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk_data

  task chk_an(input drc_analog_t g, input drc_analog_t e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected analog at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk_an

  // ----------------------------------------
  // axi4-lite master
  // ----------------------------------------
  task axi_wr(input logic [3:0] a, input logic [31:0] dd, input logic [3:0] s,
              output logic [1:0] rs);
    logic ha, hw, hb;
    @(posedge aclk);
    aw <= a; awv <= 1'b1; wd <= dd; ws <= s; wv <= 1'b1; bre <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(negedge aclk);
      ha = awv & awr; hw = wv & wr; hb = bv; rs = bresp;
      @(posedge aclk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      if (hb) begin
        bre <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    give_verdict();
  endtask : axi_wr

  task axi_rd(input logic [3:0] a, output logic [31:0] dd, output logic [1:0] rs);
    logic ha, hr;
    @(posedge aclk);
    ar <= a; arv <= 1'b1; rre <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(negedge aclk);
      ha = arv & arr; hr = rv; dd = rdata; rs = rresp;
      @(posedge aclk);
      if (ha) arv <= 1'b0;
      if (hr) begin
        rre <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    give_verdict();
  endtask : axi_rd

  task settle;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask : settle

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    aclk = 0; aresetn = 0; aw = 0; awv = 0; wd = 0; ws = 0; wv = 0; bre = 0;
    ar = 0; arv = 0; rre = 0; pin_in = 0; dig_out = 0; dig_oe = 0;
    n_mismatch = 0; checked = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(4'h0, d, r); chk_data(d, 32'h0);
    axi_rd(4'h4, d, r); chk_data(d, 32'h0);
    chk_an(an, '0);
    chk_data({28'h0, pin_out, pin_oe, pin_in_en, pin_read}, 32'h2);
    foreach (rows[k]) begin
      axi_wr(rows[k].a, {24'h0, rows[k].w}, 4'hf, r); chk_data({30'h0, r}, 32'h0);
      axi_rd(rows[k].a, d, r); chk_data(d, {24'h0, rows[k].e});
      chk_data({30'h0, r}, 32'h0);
    end
    // every source code, pin bit alternating
    for (int k = 0; k < 4; k++) begin
      sc = k[1:0]; lv = 8'h5a ^ {6'h0, sc};
      c = {1'b1, 1'b0, sc[0], 1'b0, sc, 2'b00};
      axi_wr(4'h0, {24'h0, c}, 4'hf, r);
      axi_wr(4'h4, {24'h0, lv}, 4'hf, r);
      settle();
      chk_an(an, {3'b111, c[5], sc, lv});
      axi_rd(4'h0, d, r); chk_data(d, {24'h0, c});
    end
    axi_wr(4'h0, 32'h0, 4'hf, r); settle();
    chk_an(an, '0);
    // pin override while level is on the pin
    @(posedge aclk);
    dig_out <= 1'b1; dig_oe <= 1'b1; pin_in <= 1'b1;
    axi_wr(4'h0, 32'ha0, 4'hf, r); settle();
    chk_data({28'h0, pin_out, pin_oe, pin_in_en, pin_read}, 32'h0);
    axi_rd(4'h8, d, r); chk_data(d, 32'h1);
    axi_wr(4'h0, 32'h0c, 4'hf, r); settle();
    chk_data({28'h0, pin_out, pin_oe, pin_in_en, pin_read}, 32'hf);
    axi_rd(4'h8, d, r); chk_data(d, 32'h6);
    // unmapped place and masked write
    axi_wr(4'hc, 32'hff, 4'hf, r); chk_data({30'h0, r}, 32'h2);
    axi_rd(4'hc, d, r); chk_data({d[29:0], r}, 32'h2);
    axi_wr(4'h4, 32'h77, 4'h0, r);
    axi_rd(4'h4, d, r); chk_data(d, {24'h0, lv});
    // reset in mid-run
    axi_wr(4'h0, 32'ha8, 4'hf, r);
    axi_wr(4'h4, 32'h99, 4'hf, r); settle();
    chk_an(an, {3'b111, 1'b1, 2'b10, 8'h99});
    @(posedge aclk); aresetn <= 1'b0;
    repeat (4) @(posedge aclk); aresetn <= 1'b1;
    axi_rd(4'h0, d, r); chk_data(d, 32'h0);
    axi_rd(4'h4, d, r); chk_data(d, 32'h0);
    chk_an(an, '0);
    give_verdict();
  end
endmodule : drc_top_tb

// [verilog/drc_params.svh]
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH

// register byte addresses
`define DRC_CONTROL_ADDR 4'h0
`define DRC_LEVEL_ADDR 4'h4
`define DRC_STATUS_ADDR 4'h8

// control register fields
`define DRC_ON_BIT 7
`define DRC_PIN_BIT 5
`define DRC_SRC_HI 3
`define DRC_SRC_LO 2
`define DRC_CONTROL_MASK 8'hac

// reset values
`define DRC_CONTROL_RST 8'h00
`define DRC_LEVEL_RST 8'h00

// axi response codes
`define DRC_RESP_OKAY 2'h0
`define DRC_RESP_SLVERR 2'h2

`endif

// [verilog/drc_pkg.sv]
package drc_pkg;

  typedef enum logic [1:0] {
    DRC_SRC_SUPPLY,
    DRC_SRC_EXTPIN,
    DRC_SRC_FIXED,
    DRC_SRC_RSVD
  } drc_src_t;

  typedef struct packed {
    logic converter_on;
    logic pin_drive_on;
    drc_src_t positive_source_sel;
  } drc_ctrl_t;

  typedef struct packed {
    logic converter_on;
    logic to_comparator;
    logic to_adc;
    logic to_pin;
    drc_src_t positive_source_sel;
    logic [7:0] level_code;
  } drc_analog_t;

endpackage : drc_pkg

// [verilog/drc_top.sv]
// What this block does
// - converter runs only while control bit 7 is set; otherwise off.
// - the whole level register is an 8-bit code choosing one of 256 levels.
// - output is ground plus reference span times code over 256 when enabled.
// - bits 3:2 choose supply, external pin or fixed reference; 11 is reserved.
// - bit 5 places the level on the output pin; clear disconnects the pin.
// - pin output enables override the digital driver and input detector.
// - reads of the pin while it carries the level return zero.
// - level is routed to the comparator input, an ADC channel and the pin.
// - wake from sleep leaves the control register unchanged.
// - reset disables converter, frees pin, clears code; all bits reset zero.
// - unimplemented control bits ignore writes and read as zero.
`timescale 1ns/1ps
`include "drc_params.svh"

module drc_top
  import drc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // reference output pin, digital side
  input wire logic pin_in,
  input wire logic pin_dig_out,
  input wire logic pin_dig_oe,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_in_en,
  output logic pin_read,
  // analog controls
  output drc_analog_t analog
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0] strb);
    merge_byte = strb[0] ? wd[7:0] : old_v;
  endfunction : merge_byte

  function automatic logic [7:0] ctrl_to_byte(input drc_ctrl_t c);
    logic [7:0] b;
    b = 8'h00;
    b[`DRC_ON_BIT] = c.converter_on;
    b[`DRC_PIN_BIT] = c.pin_drive_on;
    b[`DRC_SRC_HI:`DRC_SRC_LO] = c.positive_source_sel;
    ctrl_to_byte = b;
  endfunction : ctrl_to_byte

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  logic pin_meta_ff;
  logic pin_sync_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  logic aw_held_ff;
  logic w_held_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic do_write;

  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_ff && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `DRC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (awaddr_ff == `DRC_CONTROL_ADDR || awaddr_ff == `DRC_LEVEL_ADDR ||
                   awaddr_ff == `DRC_STATUS_ADDR) ? `DRC_RESP_OKAY : `DRC_RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  drc_ctrl_t ctrl_ff;
  logic [7:0] level_ff;
  logic [7:0] nxt_ctrl_byte;

  assign nxt_ctrl_byte = merge_byte(ctrl_to_byte(ctrl_ff), wdata_ff, wstrb_ff);

  // no sleep input: wake cannot disturb the stored control state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= drc_ctrl_t'(4'h0);
    end else if (do_write && awaddr_ff == `DRC_CONTROL_ADDR) begin
      ctrl_ff.converter_on <= nxt_ctrl_byte[`DRC_ON_BIT];
      ctrl_ff.pin_drive_on <= nxt_ctrl_byte[`DRC_PIN_BIT];
      ctrl_ff.positive_source_sel <= drc_src_t'(nxt_ctrl_byte[`DRC_SRC_HI:`DRC_SRC_LO]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_ff <= `DRC_LEVEL_RST;
    end else if (do_write && awaddr_ff == `DRC_LEVEL_ADDR) begin
      level_ff <= merge_byte(level_ff, wdata_ff, wstrb_ff);
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic [7:0] status_byte;

  // pin level reads as zero while the pin carries the level
  assign status_byte = {5'h00, pin_sync_ff && !ctrl_ff.pin_drive_on,
                        ctrl_ff.positive_source_sel == DRC_SRC_RSVD,
                        ctrl_ff.converter_on && ctrl_ff.pin_drive_on};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DRC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DRC_RESP_OKAY;
      unique case (s_axi_araddr)
        `DRC_CONTROL_ADDR: s_axi_rdata <= {24'h0, ctrl_to_byte(ctrl_ff)};
        `DRC_LEVEL_ADDR: s_axi_rdata <= {24'h0, level_ff};
        `DRC_STATUS_ADDR: s_axi_rdata <= {24'h0, status_byte};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `DRC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin and analog steering
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      pin_in_en <= 1'b1;
      pin_read <= 1'b0;
    end else begin
      pin_out <= ctrl_ff.pin_drive_on ? 1'b0 : pin_dig_out;
      pin_oe <= ctrl_ff.pin_drive_on ? 1'b0 : pin_dig_oe;
      pin_in_en <= !ctrl_ff.pin_drive_on;
      pin_read <= ctrl_ff.pin_drive_on ? 1'b0 : pin_sync_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog <= '0;
    end else begin
      analog.converter_on <= ctrl_ff.converter_on;
      analog.to_comparator <= ctrl_ff.converter_on;
      analog.to_adc <= ctrl_ff.converter_on;
      analog.to_pin <= ctrl_ff.converter_on && ctrl_ff.pin_drive_on;
      analog.positive_source_sel <= ctrl_ff.positive_source_sel;
      analog.level_code <= ctrl_ff.converter_on ? level_ff : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  converter_follows_a: assert property (@(posedge aclk) disable iff (!aresetn)
    analog.converter_on == $past(ctrl_ff.converter_on))
    else $error("converter enable does not follow control bit");
  level_applied_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 analog.converter_on |-> analog.level_code == $past(level_ff))
    else $error("level code not applied");
  level_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !analog.converter_on |-> analog.level_code == 8'h00)
    else $error("level present while converter off");
  source_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 analog.positive_source_sel == $past(ctrl_ff.positive_source_sel))
    else $error("source select mismatch");
  pin_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    analog.to_pin |-> $past(ctrl_ff.pin_drive_on))
    else $error("pin driven without enable");
  pin_override_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ctrl_ff.pin_drive_on) |-> !pin_oe && !pin_in_en)
    else $error("digital pin not overridden");
  pin_read_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ctrl_ff.pin_drive_on) |-> pin_read == 1'b0)
    else $error("pin read nonzero while analog");
  reset_clear_a: assert property (@(posedge aclk)
    !aresetn |=> ctrl_ff == drc_ctrl_t'(4'h0) && level_ff == 8'h00)
    else $error("reset did not clear control");
  write_next_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && awaddr_ff == `DRC_LEVEL_ADDR && wstrb_ff[0] |=> level_ff == $past(wdata_ff[7:0]))
    else $error("level write not taken next edge");

endmodule : drc_top
